// ===== hw/eeprom_protect_pkg.sv
// Constants shared by the serial EEPROM protection logic
package eeprom_protect_pkg;
    // Instruction codes
    localparam logic [7:0] CMD_READ = 8'h03;
    localparam logic [7:0] CMD_WRITE = 8'h02;
    localparam logic [7:0] CMD_LATCH_SET = 8'h06;
    localparam logic [7:0] CMD_LATCH_CLR = 8'h04;
    localparam logic [7:0] CMD_STATUS_READ = 8'h05;
    localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
    // Status register bit positions
    localparam int SR_PIN_PROTECT_ENABLE = 7;
    localparam int SR_BLOCK_PROTECT_HI = 3;
    localparam int SR_BLOCK_PROTECT_LO = 2;
    localparam int SR_WRITE_LATCH = 1;
    localparam int SR_WRITE_BUSY = 0;
    // Protection boundaries
    localparam logic [12:0] ADDR_QUARTER = 13'h1800;
    localparam logic [12:0] ADDR_HALF = 13'h1000;
    // Non-volatile bit values after reset (stand-in for stored values)
    localparam logic NV_PPE_RESET = 1'b0;
    localparam logic [1:0] NV_BP_RESET = 2'h0;
    // Frame lengths in link clock edges
    localparam logic [5:0] BITS_CMD = 6'h08;
    localparam logic [5:0] BITS_STATUS_WR = 6'h10;
    localparam logic [5:0] BITS_HDR = 6'h18;
    // Write cycle time
    localparam int WRITE_TIME_US = 5000;
    localparam int CLK_MHZ = 100;
    localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
endpackage

// ===== hw/eeprom_write_protect.sv
// Write protection, write latch and write-cycle start for the serial EEPROM
`timescale 1ns/100ps
// Operation
// - Block-protect 00 protects nothing, 11 protects 0000h to 1FFFh.
// - Block-protect 01 refuses writes to 1800h through 1FFFh.
// - Block-protect 10 refuses writes to 1000h through 1FFFh.
// - Non-volatile pin-protect-enable bit gates the write-protect pin.
// - Hardware protection active only with pin low and enable bit one.
// - Hardware protection off when pin high or enable bit zero.
// - Hardware protection blocks only non-volatile status bit updates.
// - Write latch clears at power-up.
// - Latch clears after byte, page or status write completes.
// - Write cycle starts only on a correctly timed deselect.
// - Array accesses during a write cycle are ignored.
// - After power-up the device idles deselected.
// - Data output is high impedance at power-up.
// - Device activates only after a chip-select falling edge.
// - Status write updates the block-protect bits.
// - Status layout: enable bit7, protect bits 3:2, latch bit1, busy bit0.
// - Busy flag reads one during a write cycle, else zero.
module eeprom_write_protect
#(
    parameter int WRITE_CYCLES = eeprom_protect_pkg::WRITE_CYCLES
)
(
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    input wire logic wp_n_i,
    output logic so_o,
    output logic so_oe_n_o,
    output logic [7:0] status_o,
    output logic hw_protect_o,
    output logic write_start_o,
    output logic [12:0] write_addr_o,
    output logic array_read_o
);
    typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_ACTIVE = 2'b01, ST_WAIT = 2'b11} frame_state_t;

    logic [2:0] init_q;
    logic sck_lvl;
    logic sck_rise;
    logic sck_fall;
    logic cs_lvl;
    logic cs_rise;
    logic cs_fall;
    logic si_lvl;
    logic wp_lvl;
    logic wp_meta_q;
    logic wp_sync_q;
    logic si_meta_q;
    logic si_sync_q;

    frame_state_t state_q, state_d;
    logic [5:0] bits_q, bits_d;
    logic [7:0] cmd_q, cmd_d;
    logic [23:0] shift_q, shift_d;
    logic [12:0] addr_q, addr_d;
    logic [7:0] sr_data_q, sr_data_d;
    logic latch_q, latch_d;
    logic ppe_q, ppe_d;
    logic [1:0] bp_q, bp_d;
    logic busy_q, busy_d;
    logic [31:0] cnt_q, cnt_d;
    logic start_q, start_d;
    logic [12:0] waddr_q, waddr_d;
    logic so_q, so_d;
    logic oe_n_q, oe_n_d;
    logic rd_q, rd_d;
    logic [7:0] out_q, out_d;

    // Quarter-block decode, used for both address checks
    function automatic logic addr_protected(input logic [1:0] bp, input logic [12:0] a);
        case (bp)
            2'h0: addr_protected = 1'b0;
            2'h1: addr_protected = (a >= eeprom_protect_pkg::ADDR_QUARTER);
            2'h2: addr_protected = (a >= eeprom_protect_pkg::ADDR_HALF);
            default: addr_protected = 1'b1;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Edges stay masked until sync_q and prev_q both hold real pin samples,
    // so a pin that idles opposite to the reset level gives no false edge
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            init_q <= 3'h7;
            wp_meta_q <= 1'b1;
            wp_sync_q <= 1'b1;
            si_meta_q <= 1'b0;
            si_sync_q <= 1'b0;
        end
        else
        begin
            init_q <= {init_q[1:0], 1'b0};
            wp_meta_q <= wp_n_i;
            wp_sync_q <= wp_meta_q;
            si_meta_q <= si_i;
            si_sync_q <= si_meta_q;
        end
    end
    assign wp_lvl = wp_sync_q;
    assign si_lvl = si_sync_q;

    pin_sync u_sck_sync (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .pin_i(sck_i), .init_i(init_q[2]),
        .level_o(sck_lvl), .rise_o(sck_rise), .fall_o(sck_fall));
    pin_sync u_cs_sync (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .pin_i(cs_n_i), .init_i(init_q[2]),
        .level_o(cs_lvl), .rise_o(cs_rise), .fall_o(cs_fall));

    // Hardware protection is a plain AND of pin-low and enable bit
    assign hw_protect_o = ppe_q & ~wp_lvl;

    // ------------------------------------------------------------
    // Frame decode and write control, next state
    // ------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        bits_d = bits_q;
        cmd_d = cmd_q;
        shift_d = shift_q;
        addr_d = addr_q;
        sr_data_d = sr_data_q;
        latch_d = latch_q;
        ppe_d = ppe_q;
        bp_d = bp_q;
        busy_d = busy_q;
        cnt_d = cnt_q;
        start_d = 1'b0;
        waddr_d = waddr_q;
        so_d = so_q;
        oe_n_d = oe_n_q;
        rd_d = 1'b0;
        out_d = out_q;
        // Self-timed write cycle; busy drops when the count runs out
        if (busy_q)
        begin
            if (cnt_q == 32'h0000_0001)
            begin
                busy_d = 1'b0;
                latch_d = 1'b0;
            end
            cnt_d = cnt_q - 32'h0000_0001;
        end
        case (state_q)
            ST_IDLE:
            begin
                oe_n_d = 1'b1;
                if (cs_fall)
                begin
                    state_d = ST_ACTIVE;
                    bits_d = 6'h00;
                    cmd_d = 8'h00; // No command carried over from the last frame
                end
            end
            ST_ACTIVE:
            begin
                if (cs_rise)
                begin
                    state_d = ST_IDLE;
                    oe_n_d = 1'b1;
                    // Deselect exactly on a byte boundary of the right command
                    if (cmd_q == eeprom_protect_pkg::CMD_LATCH_SET && bits_q == eeprom_protect_pkg::BITS_CMD)
                        latch_d = 1'b1;
                    else if (cmd_q == eeprom_protect_pkg::CMD_LATCH_CLR && bits_q == eeprom_protect_pkg::BITS_CMD)
                        latch_d = 1'b0;
                    else if (cmd_q == eeprom_protect_pkg::CMD_STATUS_WRITE
                             && bits_q == eeprom_protect_pkg::BITS_STATUS_WR && latch_q && !busy_q)
                    begin
                        if (!hw_protect_o)
                        begin
                            ppe_d = sr_data_q[eeprom_protect_pkg::SR_PIN_PROTECT_ENABLE];
                            bp_d = sr_data_q[eeprom_protect_pkg::SR_BLOCK_PROTECT_HI:
                                             eeprom_protect_pkg::SR_BLOCK_PROTECT_LO];
                            busy_d = 1'b1;
                            cnt_d = 32'(WRITE_CYCLES);
                            start_d = 1'b1;
                        end
                        else
                            latch_d = 1'b0; // Refused update still ends the enable
                    end
                    else if (cmd_q == eeprom_protect_pkg::CMD_WRITE && bits_q > eeprom_protect_pkg::BITS_HDR
                             && bits_q[2:0] == 3'h0 && latch_q && !busy_q)
                    begin
                        if (!addr_protected(bp_q, addr_q))
                        begin
                            busy_d = 1'b1;
                            cnt_d = 32'(WRITE_CYCLES);
                            start_d = 1'b1;
                            waddr_d = addr_q;
                        end
                    end
                end
                else if (sck_rise)
                begin
                    // Count wraps from 3Fh back to 38h so long page writes keep byte parity
                    bits_d = (bits_q == 6'h3f) ? 6'h38 : bits_q + 6'h01;
                    shift_d = {shift_q[22:0], si_lvl};
                    if (bits_q == 6'h07)
                        cmd_d = {shift_q[6:0], si_lvl};
                    if (bits_q == 6'h0f)
                        sr_data_d = {shift_q[6:0], si_lvl};
                    if (bits_q == 6'h17)
                    begin
                        addr_d = {shift_q[11:0], si_lvl};
                        // Reads during a write cycle are ignored
                        rd_d = (cmd_q == eeprom_protect_pkg::CMD_READ) && !busy_q;
                    end
                    if (bits_q == 6'h07 && {shift_q[6:0], si_lvl} == eeprom_protect_pkg::CMD_STATUS_READ)
                        out_d = status_o;
                end
                else if (sck_fall && cmd_q == eeprom_protect_pkg::CMD_STATUS_READ && bits_q >= 6'h08)
                begin
                    so_d = out_q[7];
                    out_d = {out_q[6:0], out_q[7]};
                    oe_n_d = 1'b0;
                end
            end
            default:
                state_d = ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Reset stands for power-up: latch cleared, output floating
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state_q <= ST_IDLE;
            bits_q <= 6'h00;
            cmd_q <= 8'h00;
            shift_q <= 24'h00_0000;
            addr_q <= 13'h0000;
            sr_data_q <= 8'h00;
            latch_q <= 1'b0;
            ppe_q <= eeprom_protect_pkg::NV_PPE_RESET;
            bp_q <= eeprom_protect_pkg::NV_BP_RESET;
            busy_q <= 1'b0;
            cnt_q <= 32'h0000_0000;
            start_q <= 1'b0;
            waddr_q <= 13'h0000;
            so_q <= 1'b0;
            oe_n_q <= 1'b1;
            rd_q <= 1'b0;
            out_q <= 8'h00;
        end
        else
        begin
            state_q <= state_d;
            bits_q <= bits_d;
            cmd_q <= cmd_d;
            shift_q <= shift_d;
            addr_q <= addr_d;
            sr_data_q <= sr_data_d;
            latch_q <= latch_d;
            ppe_q <= ppe_d;
            bp_q <= bp_d;
            busy_q <= busy_d;
            cnt_q <= cnt_d;
            start_q <= start_d;
            waddr_q <= waddr_d;
            so_q <= so_d;
            oe_n_q <= oe_n_d;
            rd_q <= rd_d;
            out_q <= out_d;
        end
    end

    // Status image and outputs
    assign status_o = {ppe_q, 3'h0, bp_q, latch_q, busy_q};
    assign so_o = so_q;
    assign so_oe_n_o = oe_n_q;
    assign write_start_o = start_q;
    assign write_addr_o = waddr_q;
    assign array_read_o = rd_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_start;
        start_q;
    endsequence

    a_hw_protect_eq: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        hw_protect_o == (ppe_q && !wp_lvl)) else $error("hardware protect mismatch");
    a_start_sets_busy: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        s_start |-> busy_q) else $error("write start without busy");
    a_start_needs_latch: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        start_d |-> latch_q && !busy_q) else $error("write started without latch");
    a_start_on_deselect: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        start_d |-> cs_rise) else $error("write start not on deselect");
    a_no_protected_write: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        start_d && cmd_q == eeprom_protect_pkg::CMD_WRITE |-> !addr_protected(bp_q, addr_q))
        else $error("protected address written");
    a_bp_locked_hw: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        hw_protect_o |=> $stable(bp_q) && $stable(ppe_q)) else $error("status changed under protection");
    a_latch_clears_end: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        $fell(busy_q) |-> !latch_q) else $error("latch kept after write");
    a_idle_floats: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        state_q == ST_IDLE |=> so_oe_n_o) else $error("output driven while deselected");
endmodule

// ===== hw/pin_sync.sv
// Two-flop synchroniser with edge detection on the synchronised level
`timescale 1ns/100ps
module pin_sync
(
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic pin_i,
    input wire logic init_i,
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // ------------------------------------------------------------
    // Synchroniser chain
    // ------------------------------------------------------------
    // Only sync_q looks at meta_q
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            prev_q <= 1'b1;
        end
        else
        begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Edges from the synchronised copies only
    assign level_o = sync_q;
    assign rise_o = sync_q & ~prev_q & ~init_i;
    assign fall_o = ~sync_q & prev_q & ~init_i;
endmodule

// ===== verification/serial_eeprom_write_protect_bench.sv
// Self-checking bench for the EEPROM write protection block
`timescale 1ns/100ps
module serial_eeprom_write_protect_bench;
    // Short write cycle keeps the run brief
    localparam int WCYC = 1000;
    logic ref_clk_i, resetn_i, wp_n_i, sck, cs_n, si, so, so_oe_n, hw_prot, wr_start, arr_read;
    logic [7:0] status;
    logic [12:0] wr_addr, a;
    logic [1:0] bp;
    int miscompares = 0;
    int comparisons = 0;
    int starts = 0;
    int reads = 0;
    int n0, k;

    spi_host_model spi_host_model_inst (.sck_o(sck), .cs_n_o(cs_n), .si_o(si));
    eeprom_write_protect #(.WRITE_CYCLES(WCYC)) eeprom_write_protect_inst (.ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si), .wp_n_i(wp_n_i), .so_o(so),
        .so_oe_n_o(so_oe_n), .status_o(status), .hw_protect_o(hw_prot), .write_start_o(wr_start),
        .write_addr_o(wr_addr), .array_read_o(arr_read));

    // 100 MHz system clock
    initial
    begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    // Count one-cycle pulses so no pulse is missed between checks
    always @(posedge ref_clk_i)
    begin
        if (wr_start === 1'b1) starts++;
        if (arr_read === 1'b1) reads++;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
        comparisons++;
        if (exp !== seen)
        begin
            $display("ERROR %s expected %h seen %h", name, exp, seen);
            miscompares++;
        end
    endtask

    task automatic print_verdict;
        if (miscompares == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Bounded wait for the busy flag to drop
    task automatic wait_idle;
        int i;
        for (i = 0; i < 3000 && status[0] !== 1'b0; i++) @(posedge ref_clk_i);
        if (status[0] !== 1'b0)
        begin
            miscompares++;
            print_verdict();
        end
    endtask

    task automatic latch_set;
        spi_host_model_inst.frame({24'h0, eeprom_protect_pkg::CMD_LATCH_SET}, 8);
    endtask

    task automatic status_wr(input logic [7:0] v);
        latch_set();
        spi_host_model_inst.frame({16'h0, eeprom_protect_pkg::CMD_STATUS_WRITE, v}, 16);
        wait_idle();
    endtask

    // Status read over the link; so is taken on the host's sampling edge
    task automatic status_rd(input logic [7:0] exp);
        logic [7:0] v;
        logic oe;
        v = 8'h00;
        oe = 1'b0;
        fork
            spi_host_model_inst.frame({16'h0, eeprom_protect_pkg::CMD_STATUS_READ, 8'h00}, 16);
            begin
                repeat (8) @(posedge sck);
                repeat (8)
                begin
                    @(posedge sck);
                    v = {v[6:0], so};
                    oe = oe | so_oe_n;
                end
            end
        join
        check("status over link", 32'(exp), 32'(v));
        check("output enable in read", 0, 32'(oe));
        check("output released", 1, 32'(so_oe_n));
    endtask

    // Array write of nbits leading bits; exp says whether a cycle must start
    task automatic arr_wr(input logic [12:0] adr, input logic set, input logic exp, input int nbits);
        logic [31:0] w;
        w = {eeprom_protect_pkg::CMD_WRITE, 3'h0, adr, 8'($urandom)};
        n0 = starts;
        if (set) latch_set();
        spi_host_model_inst.frame(w >> (32 - nbits), nbits);
        check("write starts", 32'(exp), starts - n0);
        if (exp)
        begin
            check("write address", 32'(adr), 32'(wr_addr));
            check("busy flag", 1, 32'(status[0]));
            wait_idle();
            check("latch after write", 0, 32'(status[1]));
        end
    endtask

    // Expected refusal for a protect level and address
    function automatic logic refused(input logic [1:0] lvl, input logic [12:0] adr);
        case (lvl)
            2'h0: return 1'b0;
            2'h1: return adr >= eeprom_protect_pkg::ADDR_QUARTER;
            2'h2: return adr >= eeprom_protect_pkg::ADDR_HALF;
            default: return 1'b1;
        endcase
    endfunction

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        resetn_i = 1'b0;
        wp_n_i = 1'b1;
        void'($urandom(32'hbdd4));
        repeat (2) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        check("status at power-up", 8'h00, status);
        check("output enable", 1, so_oe_n);
        arr_wr(13'h0000, 1'b0, 1'b0, 32);
        latch_set();
        check("latch set", 1, status[1]);
        arr_wr(13'h0010, 1'b0, 1'b0, 31);
        // Every protect level with boundary and random addresses
        for (int l = 0; l < 4; l++)
        begin
            bp = 2'(l);
            status_wr({4'h0, bp, 2'h0});
            check("block protect", {4'h0, bp, 2'h0}, status);
            for (k = 0; k < 7; k++)
            begin
                case (k)
                    0: a = eeprom_protect_pkg::ADDR_HALF - 13'h1;
                    1: a = eeprom_protect_pkg::ADDR_HALF;
                    2: a = eeprom_protect_pkg::ADDR_QUARTER - 13'h1;
                    3: a = eeprom_protect_pkg::ADDR_QUARTER;
                    4: a = 13'h1fff;
                    default: a = 13'($urandom);
                endcase
                arr_wr(a, 1'b1, !refused(bp, a), 32);
            end
        end
        // Slow host, then accesses during a running write cycle
        spi_host_model_inst.half_ns = 250.0;
        status_wr(8'h00);
        spi_host_model_inst.half_ns = 62.5;
        n0 = starts;
        latch_set();
        spi_host_model_inst.frame({eeprom_protect_pkg::CMD_WRITE, 16'h0040, 8'h5a}, 32);
        spi_host_model_inst.frame({eeprom_protect_pkg::CMD_WRITE, 16'h0080, 8'ha5}, 32);
        k = reads;
        spi_host_model_inst.frame({8'h0, eeprom_protect_pkg::CMD_READ, 16'h0040}, 24);
        check("starts while busy", 1, starts - n0);
        check("address kept", 13'h0040, wr_addr);
        check("reads while busy", 0, reads - k);
        status_rd(8'h03);
        wait_idle();
        spi_host_model_inst.frame({8'h0, eeprom_protect_pkg::CMD_READ, 16'h0040}, 24);
        check("read when idle", 1, reads - k);
        // Pin protection
        status_wr(8'h80);
        check("pin enable bit", 8'h80, status);
        @(posedge ref_clk_i);
        wp_n_i <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
        check("hw protect on", 1, hw_prot);
        status_wr(8'h8c);
        check("status locked", 8'h80, status);
        status_rd(8'h80);
        latch_set();
        check("latch under hw protect", 1, status[1]);
        arr_wr(13'h1fff, 1'b0, 1'b1, 32);
        wp_n_i <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        check("hw protect pin high", 0, hw_prot);
        status_wr(8'h00);
        check("enable cleared", 8'h00, status);
        wp_n_i <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
        check("hw protect bit low", 0, hw_prot);
        print_verdict();
    end
endmodule

// ===== verification/spi_host_model.sv
// Behavioural SPI host that frames commands for the EEPROM
`timescale 1ns/100ps
module spi_host_model
(
    output logic sck_o,
    output logic cs_n_o,
    output logic si_o
);
    // Half period of the link clock; the bench raises it for a slow host
    realtime half_ns = 62.5;

    // Deselected, clock low at power-up
    initial
    begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
    end

    // ----------------------------------------
    // Frame
    // ----------------------------------------
    // Clock idles low outside frames; data changes only while it is low
    // Non-blocking updates never race the sampling clock edge
    task automatic frame(input logic [31:0] data, input int nbits);
        int i;
        cs_n_o <= 1'b0;
        #(half_ns);
        for (i = nbits - 1; i >= 0; i--)
        begin
            si_o <= data[i];
            #(half_ns);
            sck_o <= 1'b1;
            #(half_ns);
            sck_o <= 1'b0;
        end
        // Released line flips so a stale bit is never trusted
        si_o <= ~si_o;
        #(half_ns);
        cs_n_o <= 1'b1;
        #(2 * half_ns);
    endtask
endmodule
